// ---- eri_params.svh ----
`ifndef ERI_PARAMS_SVH
`define ERI_PARAMS_SVH

// Register byte addresses.
`define ERI_ERR_EN_OFFS 12'h370
`define ERI_RISE_EN_OFFS 12'h374
`define ERI_ERR_STAT_OFFS 12'h380
`define ERI_RISE_STAT_OFFS 12'h384
`define ERI_MAIN_STAT_OFFS 12'h388
`define ERI_MAIN_MASK_OFFS 12'h38c

// Error enable / status field positions.
`define ERI_IN_FRAME_BIT 27
`define ERI_IN_TIMING_BIT 26
`define ERI_IN_DATA_BIT 25
`define ERI_IN_XFER_BIT 24
`define ERI_OUT_FRAME_BIT 19
`define ERI_OUT_TIMING_BIT 18
`define ERI_OUT_DATA_BIT 17
`define ERI_OUT_XFER_BIT 16
`define ERI_CONV_TWO_BIT 1
`define ERI_CONV_ONE_BIT 0
`define ERI_ERR_VALID_MASK 32'h0f0f0003
`define ERI_RISE_VALID_MASK 32'h000000ff

// Main status field positions.
`define ERI_MAIN_ERR_BIT 0
`define ERI_MAIN_RISE_BIT 1

// Reset values.
`define ERI_ERR_EN_RST 32'h00000000
`define ERI_RISE_EN_RST 32'h00000000
`define ERI_MAIN_MASK_RST 2'h3

// AXI responses.
`define ERI_RESP_OKAY 2'h0
`define ERI_RESP_SLVERR 2'h2

`endif

// ---- eri_pkg.sv ----
package eri_pkg;
    typedef logic [31:0] eri_word_t;
    typedef logic [1:0] eri_resp_t;
    typedef enum logic [1:0] {ERI_W_IDLE, ERI_W_RESP} eri_wstate_t;
    typedef enum logic [1:0] {ERI_R_IDLE, ERI_R_RESP} eri_rstate_t;
endpackage

// ---- eri_irq_enable.sv ----
`timescale 1ns/1ps
`include "eri_params.svh"
// Overview of operation
// - Error enable bit 27 gates input-sequencer frame fault interrupts.
// - Error enable bit 26 gates input-sequencer timing fault interrupts.
// - Error enable bit 25 gates input-sequencer data fault interrupts.
// - Error enable bit 24 gates input-sequencer transfer fault interrupts.
// - Error enable bit 19 gates output-sequencer frame fault interrupts.
// - Error enable bit 18 gates output-sequencer timing fault interrupts.
// - Error enable bit 17 gates output-sequencer data fault interrupts.
// - Error enable bit 16 gates output-sequencer transfer fault interrupts.
// - Error enable bit 1 gates second converter fault interrupts.
// - Error enable bit 0 gates first converter fault interrupts.
// - In the low half only bits 1 and 0 exist; others reserved.
// - Rise enable bit n-1 enables rising-edge interrupts of line n.
// - Rise enable bits 31 to 8 are reserved.
// - A status bit latches only if its enable was set before the event.
// - Clearing an enable keeps already pending status bits set.
// - Main error summary reads 1 while any error status bit is set.
// - Interrupt request is high while any main status bit is set whose main mask bit is also set.
module eri_irq_enable #(
    parameter int LINES = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [31:0] err_event,
    input wire logic [LINES-1:0] line_in,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output eri_pkg::eri_resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output eri_pkg::eri_word_t s_axi_rdata,
    output eri_pkg::eri_resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    import eri_pkg::*;

    if (LINES != 8) begin : g_lines_check
        $error("eri_irq_enable serves exactly eight lines");
    end

    // =====================================================================
    // Line input synchronisers and rising-edge detection
    // =====================================================================
    logic [LINES-1:0] line_s1_ff, line_s2_ff, line_s3_ff;
    logic [LINES-1:0] nxt_line_s1, nxt_line_s2, nxt_line_s3;
    logic [31:0] err_s1_ff, err_s2_ff;
    logic [31:0] nxt_err_s1, nxt_err_s2;
    logic [LINES-1:0] line_rise;

    // Error sources come from other logic blocks but may run off separate strobes,
    // so they are synchronised too; they are treated as one-cycle-or-longer levels.
    always_comb begin
        nxt_line_s1 = line_in;
        nxt_line_s2 = line_s1_ff;
        nxt_line_s3 = line_s2_ff;
        nxt_err_s1 = err_event;
        nxt_err_s2 = err_s1_ff;
        line_rise = line_s2_ff & ~line_s3_ff;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            line_s1_ff <= '0;
            line_s2_ff <= '0;
            line_s3_ff <= '0;
            err_s1_ff <= '0;
            err_s2_ff <= '0;
        end else begin
            line_s1_ff <= nxt_line_s1;
            line_s2_ff <= nxt_line_s2;
            line_s3_ff <= nxt_line_s3;
            err_s1_ff <= nxt_err_s1;
            err_s2_ff <= nxt_err_s2;
        end
    end

    // =====================================================================
    // AXI4-Lite slave
    // =====================================================================
    eri_wstate_t wst_ff, nxt_wst;
    eri_rstate_t rst_st_ff, nxt_rst_st;
    logic aw_got_ff, nxt_aw_got;
    logic w_got_ff, nxt_w_got;
    logic [11:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    eri_resp_t bresp_ff, nxt_bresp;
    eri_resp_t rresp_ff, nxt_rresp;
    eri_word_t rdata_ff, nxt_rdata;
    logic [31:0] wmask;
    logic wr_fire;

    logic [31:0] err_en_ff, nxt_err_en;
    logic [31:0] rise_en_ff, nxt_rise_en;
    logic [31:0] err_stat_ff, nxt_err_stat;
    logic [31:0] rise_stat_ff, nxt_rise_stat;
    logic [1:0] main_mask_ff, nxt_main_mask;
    logic [1:0] main_stat;
    logic irq_ff, nxt_irq;

    always_comb begin
        nxt_wst = wst_ff;
        nxt_aw_got = aw_got_ff;
        nxt_w_got = w_got_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bresp = bresp_ff;
        wr_fire = 1'b0;
        unique case (wst_ff)
            ERI_W_IDLE: begin
                // Capture only on a real handshake: the ready flops are still low at the first edge after reset.
                if (s_axi_awvalid && s_axi_awready) begin
                    nxt_aw_got = 1'b1;
                    nxt_awaddr = s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    nxt_w_got = 1'b1;
                    nxt_wdata = s_axi_wdata;
                    nxt_wstrb = s_axi_wstrb;
                end
                if (aw_got_ff && w_got_ff) begin
                    wr_fire = 1'b1;
                    nxt_aw_got = 1'b0;
                    nxt_w_got = 1'b0;
                    nxt_wst = ERI_W_RESP;
                    unique case (awaddr_ff)
                        `ERI_ERR_EN_OFFS, `ERI_RISE_EN_OFFS, `ERI_ERR_STAT_OFFS,
                        `ERI_RISE_STAT_OFFS, `ERI_MAIN_STAT_OFFS, `ERI_MAIN_MASK_OFFS: begin
                            nxt_bresp = `ERI_RESP_OKAY;
                        end
                        default: begin
                            nxt_bresp = `ERI_RESP_SLVERR;
                        end
                    endcase
                end
            end
            ERI_W_RESP: begin
                if (s_axi_bready) begin
                    nxt_wst = ERI_W_IDLE;
                end
            end
            default: begin
                nxt_wst = ERI_W_IDLE;
            end
        endcase
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{wstrb_ff[i]}};
        end
    end

    always_comb begin
        nxt_rst_st = rst_st_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        unique case (rst_st_ff)
            ERI_R_IDLE: begin
                if (s_axi_arvalid && s_axi_arready) begin
                    nxt_rst_st = ERI_R_RESP;
                    nxt_rresp = `ERI_RESP_OKAY;
                    unique case (s_axi_araddr)
                        `ERI_ERR_EN_OFFS: nxt_rdata = err_en_ff;
                        `ERI_RISE_EN_OFFS: nxt_rdata = rise_en_ff;
                        `ERI_ERR_STAT_OFFS: nxt_rdata = err_stat_ff;
                        `ERI_RISE_STAT_OFFS: nxt_rdata = rise_stat_ff;
                        `ERI_MAIN_STAT_OFFS: nxt_rdata = {30'h0, main_stat};
                        `ERI_MAIN_MASK_OFFS: nxt_rdata = {30'h0, main_mask_ff};
                        default: begin
                            nxt_rdata = 32'h0;
                            nxt_rresp = `ERI_RESP_SLVERR;
                        end
                    endcase
                end
            end
            ERI_R_RESP: begin
                if (s_axi_rready) begin
                    nxt_rst_st = ERI_R_IDLE;
                end
            end
            default: begin
                nxt_rst_st = ERI_R_IDLE;
            end
        endcase
    end

    // =====================================================================
    // Enables, pending status and interrupt
    // =====================================================================
    always_comb begin
        nxt_err_en = err_en_ff;
        nxt_rise_en = rise_en_ff;
        nxt_main_mask = main_mask_ff;
        nxt_err_stat = err_stat_ff;
        nxt_rise_stat = rise_stat_ff;
        if (wr_fire) begin
            unique case (awaddr_ff)
                `ERI_ERR_EN_OFFS: begin
                    // Reserved positions stay zero whatever is written.
                    nxt_err_en = ((err_en_ff & ~wmask) | (wdata_ff & wmask)) & `ERI_ERR_VALID_MASK;
                end
                `ERI_RISE_EN_OFFS: begin
                    nxt_rise_en = ((rise_en_ff & ~wmask) | (wdata_ff & wmask)) & `ERI_RISE_VALID_MASK;
                end
                `ERI_ERR_STAT_OFFS: begin
                    nxt_err_stat = err_stat_ff & ~(wdata_ff & wmask);
                end
                `ERI_RISE_STAT_OFFS: begin
                    nxt_rise_stat = rise_stat_ff & ~(wdata_ff & wmask);
                end
                `ERI_MAIN_MASK_OFFS: begin
                    if (wstrb_ff[0]) begin
                        nxt_main_mask = wdata_ff[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // The enable registered before this cycle gates the event, so an enable
        // written in the same cycle as an event does not catch it. Set wins over
        // clear, and an enable drop never clears a pending bit.
        nxt_err_stat = nxt_err_stat | (err_s2_ff & err_en_ff);
        nxt_rise_stat = nxt_rise_stat | ({24'h0, line_rise} & rise_en_ff);
        nxt_irq = |(main_stat & main_mask_ff);
    end

    assign main_stat[`ERI_MAIN_ERR_BIT] = |err_stat_ff;
    assign main_stat[`ERI_MAIN_RISE_BIT] = |rise_stat_ff;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wst_ff <= ERI_W_IDLE;
            rst_st_ff <= ERI_R_IDLE;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 12'h0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            bresp_ff <= `ERI_RESP_OKAY;
            rresp_ff <= `ERI_RESP_OKAY;
            rdata_ff <= 32'h0;
            err_en_ff <= `ERI_ERR_EN_RST;
            rise_en_ff <= `ERI_RISE_EN_RST;
            err_stat_ff <= 32'h0;
            rise_stat_ff <= 32'h0;
            main_mask_ff <= `ERI_MAIN_MASK_RST;
            irq_ff <= 1'b0;
        end else begin
            wst_ff <= nxt_wst;
            rst_st_ff <= nxt_rst_st;
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bresp_ff <= nxt_bresp;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
            err_en_ff <= nxt_err_en;
            rise_en_ff <= nxt_rise_en;
            err_stat_ff <= nxt_err_stat;
            rise_stat_ff <= nxt_rise_stat;
            main_mask_ff <= nxt_main_mask;
            irq_ff <= nxt_irq;
        end
    end

    // Ready and valid flags are registered from the next state so every handshake output stays flop-driven.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_rvalid <= 1'b0;
        end else begin
            s_axi_awready <= (nxt_wst == ERI_W_IDLE) && !nxt_aw_got;
            s_axi_wready <= (nxt_wst == ERI_W_IDLE) && !nxt_w_got;
            s_axi_arready <= (nxt_rst_st == ERI_R_IDLE);
            s_axi_bvalid <= (nxt_wst == ERI_W_RESP);
            s_axi_rvalid <= (nxt_rst_st == ERI_R_RESP);
        end
    end

    always_comb begin
        s_axi_bresp = bresp_ff;
        s_axi_rdata = rdata_ff;
        s_axi_rresp = rresp_ff;
        irq = irq_ff;
    end
endmodule

// ---- eri_irq_assertions.sv ----
`timescale 1ns/1ps
`include "eri_params.svh"
module eri_irq_assertions (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire eri_pkg::eri_word_t s_axi_rdata,
    input wire eri_pkg::eri_resp_t s_axi_rresp
);
    import eri_pkg::*;
    // ====
    // Bus timing.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence b_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    b_latency_a: assert property (wr_taken |=> b_answer) else $error("write answer late");
    r_latency_a: assert property (rd_taken |=> s_axi_rvalid) else $error("read answer late");
    b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
    r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
    w_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write ready early");
    ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read ready early");
    err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `ERI_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read data not zero");
    // ====
    // Reserved enable bits.
    rsv_err_a: assert property (rd_taken and s_axi_araddr == `ERI_ERR_EN_OFFS |=>
        (s_axi_rdata & ~`ERI_ERR_VALID_MASK) == 32'h0) else $error("reserved error enable bit set");
    rsv_rise_a: assert property (rd_taken and s_axi_araddr == `ERI_RISE_EN_OFFS |=>
        (s_axi_rdata & ~`ERI_RISE_VALID_MASK) == 32'h0) else $error("reserved rise enable bit set");
endmodule
bind eri_irq_enable eri_irq_assertions u_chk (.clk, .rst_b, .s_axi_araddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

// ---- testbench.sv ----
`timescale 1ns/1ps
`include "eri_params.svh"
module testbench;
    import eri_pkg::*;
    logic clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] err_event, s_axi_wdata, m_err_en, m_rise_en, m_err_st, m_rise_st;
    logic [7:0] line_in;
    logic [3:0] s_axi_wstrb;
    logic [1:0] m_mask;
    eri_resp_t s_axi_bresp, s_axi_rresp;
    eri_word_t s_axi_rdata;
    int fail_count, comparisons;
    eri_irq_enable u_dut (.clk, .rst_b, .err_event, .line_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .irq);
    // ====
    // Checking and bus tasks.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_rsp(input eri_resp_t got, input eri_resp_t exp);
        chk({30'h0, got}, {30'h0, exp});
    endtask
    task automatic finish_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input eri_resp_t er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid) @(posedge clk);
        s_axi_bready <= 1'b0;
        chk_rsp(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input eri_resp_t er);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk_rsp(s_axi_rresp, er);
    endtask
    // Error events last one cycle, so a level-only latch or a missing enable shows up as a lost bit.
    task automatic pulse(input logic [31:0] e, input logic [7:0] l);
        @(posedge clk);
        m_err_st = m_err_st | (e & m_err_en);
        m_rise_st = m_rise_st | (l & ~line_in & m_rise_en[7:0]);
        err_event <= e;
        line_in <= l;
        @(posedge clk);
        err_event <= 32'h0;
        repeat (6) @(posedge clk);
    endtask
    task automatic chk_all();
        rd(`ERI_ERR_STAT_OFFS, m_err_st, `ERI_RESP_OKAY);
        rd(`ERI_RISE_STAT_OFFS, m_rise_st, `ERI_RESP_OKAY);
        rd(`ERI_MAIN_STAT_OFFS, {30'h0, |m_rise_st, |m_err_st}, `ERI_RESP_OKAY);
        chk({31'h0, irq}, {31'h0, |({|m_rise_st, |m_err_st} & m_mask)});
    endtask
    // ====
    // Clock, watchdog and sequence.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #50000;
        fail_count++;
        finish_test();
    end
    initial begin
        {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, err_event, s_axi_wdata, line_in} = '0;
        s_axi_wstrb = 4'hf;
        {m_err_en, m_rise_en, m_err_st, m_rise_st} = '0;
        m_mask = 2'h3;
        fail_count = 0;
        comparisons = 0;
        void'($urandom(32'h8a60));
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        rd(`ERI_ERR_EN_OFFS, 32'h0, `ERI_RESP_OKAY);
        rd(`ERI_RISE_EN_OFFS, 32'h0, `ERI_RESP_OKAY);
        rd(`ERI_MAIN_MASK_OFFS, 32'h3, `ERI_RESP_OKAY);
        wr(`ERI_ERR_EN_OFFS, 32'hffffffff, `ERI_RESP_OKAY);
        rd(`ERI_ERR_EN_OFFS, 32'h0f0f0003, `ERI_RESP_OKAY);
        wr(`ERI_RISE_EN_OFFS, 32'hffffffff, `ERI_RESP_OKAY);
        rd(`ERI_RISE_EN_OFFS, 32'hff, `ERI_RESP_OKAY);
        wr(12'h3f0, 32'h1, `ERI_RESP_SLVERR);
        rd(12'h3f0, 32'h0, `ERI_RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            m_mask = i[1:0];
            wr(`ERI_MAIN_MASK_OFFS, {30'h0, m_mask}, `ERI_RESP_OKAY);
            m_err_en = $urandom;
            m_rise_en = $urandom;
            wr(`ERI_ERR_EN_OFFS, m_err_en, `ERI_RESP_OKAY);
            wr(`ERI_RISE_EN_OFFS, m_rise_en, `ERI_RESP_OKAY);
            m_err_en = m_err_en & `ERI_ERR_VALID_MASK;
            m_rise_en = m_rise_en & `ERI_RISE_VALID_MASK;
            rd(`ERI_ERR_EN_OFFS, m_err_en, `ERI_RESP_OKAY);
            rd(`ERI_RISE_EN_OFFS, m_rise_en, `ERI_RESP_OKAY);
            pulse($urandom, 8'($urandom));
            chk_all();
            wr(`ERI_ERR_EN_OFFS, 32'h0, `ERI_RESP_OKAY);
            wr(`ERI_RISE_EN_OFFS, 32'h0, `ERI_RESP_OKAY);
            {m_err_en, m_rise_en} = '0;
            pulse($urandom, 8'($urandom));
            chk_all();
            wr(`ERI_ERR_STAT_OFFS, m_err_st, `ERI_RESP_OKAY);
            wr(`ERI_RISE_STAT_OFFS, m_rise_st, `ERI_RESP_OKAY);
            {m_err_st, m_rise_st} = '0;
            chk_all();
        end
        finish_test();
    end
endmodule
